// file: inc/isu_defines.svh
// Constants of the indexed stack instruction unit: offsets, fields, reset values.
// Assumes inclusion by bare name from the design file, the checker and the bench.
`ifndef ISU_DEFINES_SVH
`define ISU_DEFINES_SVH

// APB register byte offsets
`define ISU_OFF_CTRL 8'h00
`define ISU_OFF_PTR0 8'h04
`define ISU_OFF_PTR1 8'h08
`define ISU_OFF_PTR2 8'h0c
`define ISU_OFF_STAT 8'h10

// Control register field and reset value (extension off after reset)
`define ISU_CTRL_EXT_BIT 0
`define ISU_CTRL_RESET 1'b0
`define ISU_PTR_RESET 12'h000

// Opcode prefixes
`define ISU_MOVE_W1_PFX 9'h1d7
`define ISU_MOVE_W2_PFX 4'hf
`define ISU_PUSH_PFX 8'hfa
`define ISU_SUB_PFX 8'he9
`define ISU_SEL_RET 2'b11

// Offset-mode window limit and the access bank upper half
`define ISU_OFFSET_MAX 8'h5f
`define ISU_ACC_SPLIT 8'h80
`define ISU_ACC_HI_BANK 4'hf

// Data moved when the source is an indirect register
`define ISU_IND_READ_VAL 8'h00

`endif

// file: inc/isu_pkg.sv
// Types shared by the indexed stack instruction unit.
// Assumes isu_defines.svh holds the numeric constants.
package isu_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ISU_IDLE,
    ISU_MV_READ,
    ISU_MV_DEST,
    ISU_RET_NOP
  } isu_state_t;

  // Data memory request toward the core data space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } isu_mem_req_t;

  // Remapped operand of a standard byte or bit instruction
  typedef struct packed {
    logic valid;
    logic dest_file;
    logic [11:0] addr;
  } isu_std_addr_t;

endpackage : isu_pkg

// file: src/isu_top.sv
// Indexed stack instruction unit: executes the indexed move, push-literal,
// pointer-subtract and pointer-subtract-with-return, and remaps operands of
// standard byte and bit instructions in indexed literal offset mode.
// Assumes a core that hands over instruction words with a valid strobe, a data
// memory that returns read data in the cycle of the read strobe, and an APB master.
`include "isu_defines.svh"
`timescale 1ns/1ps

module isu_top
  import isu_pkg::*;
#(
  parameter logic [11:0] IND_LO = 12'hfe0, // Lowest indirect-addressing register
  parameter logic [11:0] IND_HI = 12'hfef  // Highest indirect-addressing register
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction words from the core
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic instr_taken,
  // Data memory
  output isu_mem_req_t mem_req,
  input wire logic [7:0] mem_rd_data,
  // Return stack
  output logic ret_load,
  // Standard byte and bit operand remap
  input wire logic std_valid,
  input wire logic [7:0] std_file,
  input wire logic std_access,
  input wire logic std_dest_file,
  input wire logic [3:0] bank_select_register,
  output isu_std_addr_t std_addr
);

  // Registers
  logic ext_en_q;                    // Extension enable configuration bit
  logic [11:0] ptr_q [3];            // Three file-select pointers
  logic [11:0] ptr_d [3];            // Next pointer values
  isu_state_t state_q;               // Sequencer state
  isu_state_t state_d;
  logic [7:0] move_data_q;           // Byte carried from the move's read to its write
  logic move_src_ind_q;              // Source of the pending move was indirect
  logic move_nop_q;                  // Last move was suppressed
  isu_mem_req_t mem_req_q;
  isu_mem_req_t mem_req_d;
  logic ret_q;
  logic ready_q;
  logic taken_q;
  logic taken_d;
  isu_std_addr_t std_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Alias of the third pointer
  wire logic [11:0] third_pointer = ptr_q[2];

  // Instruction field decode
  wire logic [1:0] ptr_sel = instr_word[7:6];
  wire logic [5:0] sub_lit = instr_word[5:0];
  wire logic [6:0] src_off = instr_word[6:0];
  wire logic [7:0] push_lit = instr_word[7:0];
  wire logic accept = instr_valid & ready_q;
  wire logic is_move1 = ext_en_q & (instr_word[15:7] == `ISU_MOVE_W1_PFX);
  wire logic is_move2 = instr_word[15:12] == `ISU_MOVE_W2_PFX;
  wire logic is_push = ext_en_q & (instr_word[15:8] == `ISU_PUSH_PFX);
  wire logic is_sub = ext_en_q & (instr_word[15:8] == `ISU_SUB_PFX);
  wire logic is_ret = is_sub & (ptr_sel == `ISU_SEL_RET);

  // Move address arithmetic on the full twelve bits
  wire logic [11:0] src_addr = third_pointer + {5'h00, src_off};
  wire logic [11:0] dst_addr = third_pointer + {5'h00, instr_word[6:0]};
  wire logic src_ind = (src_addr >= IND_LO) && (src_addr <= IND_HI);
  wire logic dst_ind = (dst_addr >= IND_LO) && (dst_addr <= IND_HI);

  // Standard operand remap
  wire logic in_window = ext_en_q & ~std_access & (std_file <= `ISU_OFFSET_MAX);
  wire logic [11:0] idx_addr = third_pointer + {4'h0, std_file};
  wire logic [11:0] acc_addr = (std_file < `ISU_ACC_SPLIT) ? {4'h0, std_file}
                                                            : {`ISU_ACC_HI_BANK, std_file};
  wire logic [11:0] abs_addr = std_access ? {bank_select_register, std_file} : acc_addr;
  // With the pointer at zero the indexed sum equals the access address
  wire logic [11:0] std_eff = in_window ? idx_addr : abs_addr;

  // APB decode
  wire logic apb_acc = psel & penable;
  wire logic apb_wr = apb_acc & pready_q & pwrite;
  wire logic hit_ctrl = paddr == `ISU_OFF_CTRL;
  wire logic hit_ptr0 = paddr == `ISU_OFF_PTR0;
  wire logic hit_ptr1 = paddr == `ISU_OFF_PTR1;
  wire logic hit_ptr2 = paddr == `ISU_OFF_PTR2;
  wire logic hit_stat = paddr == `ISU_OFF_STAT;
  wire logic mapped = hit_ctrl | hit_ptr0 | hit_ptr1 | hit_ptr2 | hit_stat;
  wire logic [31:0] rd_mux =
      hit_ctrl ? {31'h0, ext_en_q} :
      hit_ptr0 ? {20'h0, ptr_q[0]} :
      hit_ptr1 ? {20'h0, ptr_q[1]} :
      hit_ptr2 ? {20'h0, ptr_q[2]} :
      hit_stat ? {28'h0, move_nop_q, 1'b0, 2'(state_q)} : 32'h0;

  // Sequencer next state and memory request
  always_comb begin
    state_d = state_q;
    mem_req_d = '0;
    taken_d = 1'b0;
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    ptr_d[2] = ptr_q[2];
    unique case (state_q)
      ISU_IDLE: begin
        if (accept & is_move1) begin
          // First cycle of the move: read the source
          mem_req_d.rd = ~src_ind;
          mem_req_d.addr = src_addr;
          taken_d = 1'b1;
          state_d = ISU_MV_READ;
        end else if (accept & is_push) begin
          // Write at the pointer, then step it down
          mem_req_d.wr = 1'b1;
          mem_req_d.addr = third_pointer;
          mem_req_d.wdata = push_lit;
          ptr_d[2] = third_pointer - 12'h001;
          taken_d = 1'b1;
        end else if (accept & is_ret) begin
          // Subtract from third pointer, then an idle cycle for the return
          ptr_d[2] = third_pointer - {6'h00, sub_lit};
          taken_d = 1'b1;
          state_d = ISU_RET_NOP;
        end else if (accept & is_sub) begin
          // Single-cycle subtract, no flags are touched here
          ptr_d[ptr_sel] = ptr_q[ptr_sel] - {6'h00, sub_lit};
          taken_d = 1'b1;
        end
      end
      ISU_MV_READ: begin
        // Read strobe is out unless the source is indirect; data is captured this cycle
        state_d = ISU_MV_DEST;
      end
      ISU_MV_DEST: begin
        if (accept & is_move2) begin
          // Second cycle: write unless the destination is indirect
          mem_req_d.wr = ~dst_ind;
          mem_req_d.addr = dst_addr;
          mem_req_d.wdata = move_data_q;
          taken_d = 1'b1;
          state_d = ISU_IDLE;
        end
      end
      ISU_RET_NOP: begin
        // Idle second cycle while the return target is fetched
        state_d = ISU_IDLE;
      end
    endcase
  end

  // Sequencer state, strobes and readiness
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ISU_IDLE;
      mem_req_q <= '0;
      ret_q <= 1'b0;
      ready_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mem_req_q <= mem_req_d;
      ret_q <= accept & is_ret & (state_q == ISU_IDLE);
      // Words are only taken in states that can decode one
      ready_q <= (state_d == ISU_IDLE) | (state_d == ISU_MV_DEST);
      taken_q <= taken_d;
    end
  end

  // Move data capture; an indirect source yields zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      move_data_q <= 8'h00;
      move_src_ind_q <= 1'b0;
      move_nop_q <= 1'b0;
    end else begin
      if (state_q == ISU_IDLE && accept && is_move1) begin
        move_src_ind_q <= src_ind;
      end
      if (state_q == ISU_MV_READ) begin
        move_data_q <= move_src_ind_q ? `ISU_IND_READ_VAL : mem_rd_data;
      end
      if (state_q == ISU_MV_DEST && accept && is_move2) begin
        move_nop_q <= dst_ind;
      end
    end
  end

  // Pointers: instruction updates that change a pointer win over a same-cycle APB write
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    wire logic hw_upd = ptr_d[i] != ptr_q[i];
    wire logic sw_upd = apb_wr & (paddr == `ISU_OFF_PTR0 + 8'(4 * i));
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ptr_q[i] <= `ISU_PTR_RESET;
      end else if (hw_upd) begin
        ptr_q[i] <= ptr_d[i];
      end else if (sw_upd) begin
        ptr_q[i] <= pwdata[11:0];
      end
    end
  end

  // Extension enable bit, off after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_en_q <= `ISU_CTRL_RESET;
    end else if (apb_wr && hit_ctrl) begin
      ext_en_q <= pwdata[`ISU_CTRL_EXT_BIT];
    end
  end

  // Standard operand remap, one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      std_q <= '0;
    end else begin
      std_q.valid <= std_valid;
      std_q.addr <= std_valid ? std_eff : std_q.addr;
      // Destination select passes through unchanged
      std_q.dest_file <= std_valid ? std_dest_file : std_q.dest_file;
    end
  end

  // APB slave: one wait state, error on unmapped offsets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~mapped;
      prdata_q <= (apb_acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign instr_ready = ready_q;
  assign instr_taken = taken_q;
  assign mem_req = mem_req_q;
  assign ret_load = ret_q;
  assign std_addr = std_q;

endmodule : isu_top

// file: testbench/isu_checker.sv
// Port assertions for the unit, bound into isu_top.
// Assumes the enable bit changes only through APB writes to the control word.
`include "isu_defines.svh"
`timescale 1ns/1ps
module isu_checker
  import isu_pkg::*;
#(
  parameter logic [11:0] IND_LO = 12'hfe0, // Lowest indirect register, bound from the unit
  parameter logic [11:0] IND_HI = 12'hfef  // Highest indirect register, bound from the unit
) (
  // Clock, reset and APB
  input wire logic clk, rst, psel, penable, pwrite, pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // Instruction side
  input wire logic instr_valid, instr_ready, instr_taken, ret_load,
  input wire logic [15:0] instr_word,
  input wire isu_mem_req_t mem_req,
  // Operand remap
  input wire logic std_valid, std_access, std_dest_file,
  input wire logic [7:0] std_file,
  input wire logic [3:0] bank_select_register,
  input wire isu_std_addr_t std_addr
);
  logic ext_q; // Enable bit as last written
  logic mv_q; // Move waiting for its second word
  wire logic tk = instr_valid && instr_ready && ext_q && !mv_q; // Fresh word taken
  wire logic [7:0] op = instr_word[15:8];
  wire logic sub = op == `ISU_SUB_PFX;
  wire logic rt = instr_word[7:6] == `ISU_SEL_RET;
  // Request address lands on an indirect register: a move makes no access there
  wire logic ind_hit = (mem_req.addr >= IND_LO) && (mem_req.addr <= IND_HI);
  // Unextended mapping; access bank split in two halves
  wire logic [11:0] nrm = std_access ? {bank_select_register, std_file} :
    std_file < `ISU_ACC_SPLIT ? {4'h0, std_file} : {`ISU_ACC_HI_BANK, std_file};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Mirrors kept only to qualify antecedents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_q <= 1'b0;
      mv_q <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == `ISU_OFF_CTRL) ext_q <= pwdata[0];
      if (tk && instr_word[15:7] == `ISU_MOVE_W1_PFX) mv_q <= 1'b1;
      else if (instr_valid && instr_ready && op[7:4] == `ISU_MOVE_W2_PFX) mv_q <= 1'b0;
    end
  end
  chk_std_absolute: assert property (
    !ext_q && std_valid |=> std_addr.valid && std_addr.addr == $past(nrm))
    else $error("operand not absolute");
  chk_std_high_kept: assert property (
    ext_q && std_valid && !std_access && std_file > `ISU_OFFSET_MAX |=> std_addr.addr == $past(nrm))
    else $error("high operand remapped");
  chk_dest_bit: assert property (
    std_valid |=> std_addr.dest_file == $past(std_dest_file)) else $error("dest bit changed");
  chk_push_write: assert property (
    tk && op == `ISU_PUSH_PFX |=> mem_req.wr && !mem_req.rd && mem_req.wdata == $past(instr_word[7:0]))
    else $error("push write wrong");
  chk_move_read: assert property (
    tk && instr_word[15:7] == `ISU_MOVE_W1_PFX |=>
      mem_req.rd == !ind_hit && !mem_req.wr && !instr_ready ##1 instr_ready)
    else $error("move first cycle wrong");
  chk_move_write: assert property (
    instr_valid && instr_ready && mv_q && op[7:4] == `ISU_MOVE_W2_PFX |=>
      mem_req.wr == !ind_hit && !mem_req.rd)
    else $error("move second cycle wrong");
  chk_taken_pulse: assert property (
    tk && (op == `ISU_PUSH_PFX || sub || instr_word[15:7] == `ISU_MOVE_W1_PFX) |=>
      instr_taken ##1 !instr_taken)
    else $error("taken pulse wrong");
  chk_sub_return: assert property (
    tk && sub && rt |=> ret_load && !instr_ready ##1 !ret_load && instr_ready)
    else $error("return cycles wrong");
  chk_sub_plain: assert property (
    tk && sub && !rt |=> !mem_req.rd && !mem_req.wr && !ret_load) else $error("subtract side effect");
  chk_off_quiet: assert property (
    !ext_q && $past(!ext_q) |-> !ret_load && !mem_req.rd && !mem_req.wr) else $error("active while off");
  cov_push: cover property (tk && op == `ISU_PUSH_PFX);
  cov_ret: cover property (ret_load);
  cov_move: cover property (mem_req.rd);
endmodule : isu_checker
bind isu_top isu_checker #(.IND_LO(IND_LO), .IND_HI(IND_HI)) chk_u (.clk, .rst, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata,
  .instr_valid, .instr_ready, .instr_taken, .ret_load, .instr_word, .mem_req, .std_valid,
  .std_access,
  .std_dest_file, .std_file, .bank_select_register, .std_addr);

// file: testbench/isu_mem_model.sv
// Data space and return stack model on the unit's far side.
// Assumes reads are answered in the cycle of the read strobe.
`timescale 1ns/1ps
module isu_mem_model
  import isu_pkg::*;
(
  // Clock and requests
  input wire logic clk,
  input wire isu_mem_req_t mem_req,
  input wire logic ret_load,
  // Read data
  output logic [7:0] mem_rd_data
);
  logic [7:0] mem [0:4095]; // Whole 4096-byte data space
  logic [7:0] last_q = 8'h00; // Last byte shown
  int ret_cnt = 0; // Returns taken
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
  // Idle bus shows the inverse so a late read is caught
  assign mem_rd_data = mem_req.rd ? mem[mem_req.addr] : ~last_q;
  always @(posedge clk) begin
    if (mem_req.rd) last_q <= mem[mem_req.addr];
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    if (ret_load) ret_cnt <= ret_cnt + 1;
  end
endmodule : isu_mem_model

// file: testbench/testbench.sv
// Self-checking bench: APB set-up, extended instructions, operand remap.
// Assumes isu_mem_model answers reads in the strobe cycle.
`include "isu_defines.svh"
`timescale 1ns/1ps
module testbench
  import isu_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic instr_valid = 1'b0, instr_ready, instr_taken, ret_load, std_valid = 1'b0;
  logic std_access = 1'b0, std_dest_file = 1'b0;
  logic [7:0] paddr = 8'h00, mem_rd_data, std_file = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] instr_word = 16'h0;
  logic [3:0] bank_select_register = 4'h9;
  logic e;
  isu_mem_req_t mem_req;
  isu_std_addr_t std_addr;
  int failures = 0, n_checks = 0, cyc = 0;
  isu_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr_word, .instr_ready, .instr_taken, .mem_req, .mem_rd_data,
    .ret_load, .std_valid, .std_file, .std_access, .std_dest_file, .bank_select_register,
    .std_addr);
  isu_mem_model mem_u (.clk, .mem_req, .ret_load, .mem_rd_data);
  initial forever #5 clk = ~clk;
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic ptr(input int i, input logic w, input logic [11:0] v);
    apb(w, `ISU_OFF_PTR0 + 8'(4 * i), {20'h0, v});
    if (!w) chk("pointer", {4'h0, v}, r[15:0]);
  endtask : ptr
  // Offer a word until instr_ready is seen
  task automatic issue(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge clk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : issue
  task automatic std(input logic [7:0] f, input logic a, input logic d, input logic [11:0] x);
    std_valid <= 1'b1;
    std_file <= f;
    std_access <= a;
    std_dest_file <= d;
    @(posedge clk);
    std_valid <= 1'b0;
    #1;
    chk("std_addr", {3'b001, d, x}, {2'b00, std_addr});
    @(posedge clk);
  endtask : std
  task automatic mchk(input logic [11:0] a, input logic [7:0] v);
    chk("memory", {8'h00, v}, {8'h00, mem_u.mem[a]});
  endtask : mchk
  // Extension off: ignored words, absolute operands
  task automatic t_off();
    apb(1'b0, `ISU_OFF_CTRL, 32'h0);
    chk("ctrl", 16'h0000, r[15:0]);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 16'h0001, {15'h0, e});
    issue(16'hfa77);
    ptr(2, 1'b0, 12'h000);
    mchk(12'h000, 8'h5a);
    std(8'h10, 1'b0, 1'b0, 12'h010);
    std(8'ha0, 1'b0, 1'b0, 12'hfa0);
    std(8'h33, 1'b1, 1'b0, 12'h933);
  endtask : t_off
  // Offset window relative to the third pointer
  task automatic t_remap();
    apb(1'b1, `ISU_OFF_CTRL, 32'h1);
    ptr(2, 1'b1, 12'h000);
    std(8'h10, 1'b0, 1'b0, 12'h010);
    ptr(2, 1'b1, 12'hff0);
    std(8'h5f, 1'b0, 1'b1, 12'h04f);
    std(8'h60, 1'b0, 1'b0, 12'h060);
  endtask : t_remap
  task automatic t_push();
    ptr(2, 1'b1, 12'h001);
    issue(16'hfaa5);
    issue(16'hfa3c);
    mchk(12'h001, 8'ha5);
    mchk(12'h000, 8'h3c);
    ptr(2, 1'b0, 12'hfff);
  endtask : t_push
  task automatic t_sub();
    int n;
    for (int i = 0; i < 3; i++) begin
      ptr(i, 1'b1, 12'h010);
      issue({8'he9, 2'(i), 6'h3f});
      ptr(i, 1'b0, 12'hfd1);
    end
    n = mem_u.ret_cnt;
    ptr(2, 1'b1, 12'h020);
    issue(16'he9c1);
    ptr(2, 1'b0, 12'h01f);
    chk("returns", 16'(n + 1), 16'(mem_u.ret_cnt));
  endtask : t_sub
  // Moves; destinations kept off counter and stack-top bytes
  task automatic t_move();
    ptr(2, 1'b1, 12'h100);
    mem_u.mem[12'h105] = 8'h33;
    issue(16'heb85);
    issue(16'hf006);
    mchk(12'h106, 8'h33);
    ptr(2, 1'b1, 12'hfd0);
    mem_u.mem[12'hfe0] = 8'h5a;
    issue(16'heb90);
    issue(16'hf07f);
    mchk(12'h04f, 8'h00);
    ptr(2, 1'b1, 12'hfe0);
    mem_u.mem[12'hfef] = 8'h77;
    issue(16'hebff);
    issue(16'hf00f);
    mchk(12'hfef, 8'h77);
    apb(1'b0, `ISU_OFF_STAT, 32'h0);
    chk("stat", 16'h0008, r[15:0]);
  endtask : t_move
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_off();
    t_remap();
    t_push();
    t_sub();
    t_move();
    tally_and_finish();
  end
endmodule : testbench
